// ===== verilog/pamx_port.sv
// port a pin multiplexer with avalon-mm register slave
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "pamx_defines.svh"

module pamx_port
#(
   parameter int ADDR_WIDTH = 22
)
(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic [ADDR_WIDTH-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [2:0] i_mode,
   input wire logic i_hw_standby_n,
   input wire logic i_sw_standby,
   input wire pamx_pkg::pamx_timer2_t i_timer2,
   input wire pamx_pkg::pamx_pattern_t i_pattern,
   input wire pamx_pkg::pamx_addr_t i_addr_hi,
   input wire logic [7:0] i_pin,
   output logic [7:0] o_pin,
   output logic [7:0] o_pin_oe,
   output logic [7:0] o_pin_level,
   output logic [1:0] o_capture_en
);

   // the index needs twenty bits above the two byte bits
   if (ADDR_WIDTH < 22)
   begin : g_check
      $error("pamx_port: ADDR_WIDTH must be at least 22");
   end

   // timer channel 2 compare b: codes 001 and 01x give setting 1
   function automatic logic timer_b_out(input logic [2:0] code);
      timer_b_out = !code[2] && (code[1] || code[0]);
   endfunction

   // compare a adds pwm mode as a reason for setting 1
   function automatic logic timer_a_out(input logic [2:0] code,
                                        input logic pwm);
      timer_a_out = pwm || timer_b_out(code);
   endfunction

   // modes 3 and 4 pin 7 is the a20 address line for good
   function automatic logic addr_fixed_mode(input logic [2:0] m);
      addr_fixed_mode = (m == `PAMX_MODE_3) || (m == `PAMX_MODE_4);
   endfunction

   logic [7:0] pin_meta;
   logic [7:0] pin_sync;
   logic [2:0] mode_meta;
   logic [2:0] mode_sync;
   logic hwsb_meta;
   logic hwsb_sync_n;
   logic [1:0] init_cnt;
   logic init_busy;
   logic hw_clear;
   logic mode34;
   logic mode_ext;
   logic [7:0] port_direction;
   logic [7:0] port_output_data;
   logic [19:0] reg_index;
   logic dir_hit;
   logic data_hit;
   logic req;
   logic take;
   logic [7:0] port_view;
   logic [7:0] next_pin;
   logic [7:0] next_oe;
   logic [1:0] next_capture_en;
   logic b_set1;
   logic a_set1;

   // pins and straps come from outside the clock domain
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
         mode_meta <= 3'h0;
         mode_sync <= 3'h0;
         hwsb_meta <= 1'h1;
         hwsb_sync_n <= 1'h1;
      end
      else
      begin
         pin_meta <= i_pin;
         pin_sync <= pin_meta;
         mode_meta <= i_mode;
         mode_sync <= mode_meta;
         hwsb_meta <= i_hw_standby_n;
         hwsb_sync_n <= hwsb_meta;
      end
   end

   // hold the init load until the mode strap has crossed the synchroniser
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
         init_cnt <= 2'h0;
      else if (!hwsb_sync_n)
         init_cnt <= 2'h0;
      else if (init_cnt != `PAMX_INIT_CYCLES)
         init_cnt <= init_cnt + 2'h1;
   end

   assign init_busy = (init_cnt != `PAMX_INIT_CYCLES);
   assign hw_clear = init_busy || !hwsb_sync_n;
   assign mode34 = addr_fixed_mode(mode_sync);
   assign mode_ext = mode34 || (mode_sync == `PAMX_MODE_5);

   // register decode; a request is taken when waitrequest is low
   assign reg_index = i_avs_address[21:2];
   assign dir_hit = (reg_index == `PAMX_DIR_INDEX);
   assign data_hit = (reg_index == `PAMX_DATA_INDEX);
   assign req = i_avs_read || i_avs_write;
   assign take = req && !o_avs_waitrequest;

   // one wait cycle per access, then a single low cycle
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
         o_avs_waitrequest <= 1'h1;
      else
         o_avs_waitrequest <= !(req && o_avs_waitrequest);
   end

   // direction: mode dependent load, writes blocked in software standby
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
         port_direction <= `PAMX_DIR_RESET_PLAIN;
      else if (hw_clear)
         port_direction <= mode34 ? `PAMX_DIR_RESET_ADDR
                                  : `PAMX_DIR_RESET_PLAIN;
      else if (take && i_avs_write && dir_hit && i_avs_byteenable[0]
               && !i_sw_standby)
      begin
         port_direction <= i_avs_writedata[7:0];
         if (mode34)
            port_direction[`PAMX_ADDR20_PIN] <= 1'h1;
      end
   end

   // output data: cleared by hardware standby only
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
         port_output_data <= `PAMX_DATA_RESET;
      else if (hw_clear)
         port_output_data <= `PAMX_DATA_RESET;
      else if (take && i_avs_write && data_hit && i_avs_byteenable[0]
               && !i_sw_standby)
         port_output_data <= i_avs_writedata[7:0];
   end

   // data where driven, pin level where input
   assign port_view = (port_output_data & port_direction)
                    | (pin_sync & ~port_direction);

   // read data is ready in the cycle waitrequest drops
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
         o_avs_readdata <= 32'h00000000;
      else if (i_avs_read && o_avs_waitrequest)
      begin
         if (dir_hit)
            o_avs_readdata <= {24'h000000, `PAMX_DIR_READBACK};
         else if (data_hit)
            o_avs_readdata <= {24'h000000, port_view};
         else
            o_avs_readdata <= 32'h00000000;
      end
   end

   // timer channel 2 wins pins 7/6 only outside address use
   assign b_set1 = timer_b_out(i_timer2.io_ctrl_b);
   assign a_set1 = timer_a_out(i_timer2.io_ctrl_a,
                               i_timer2.pwm_select);

   // pins 5 to 0: address (5,4 only), else pattern or plain port
   for (genvar i = 0; i < 6; i++)
   begin : g_low
      logic addr_use;
      if (i >= 4)
      begin : g_addr
         assign addr_use = mode_ext && i_addr_hi.enable[7-i];
      end
      else
      begin : g_none
         assign addr_use = 1'b0;
      end
      assign next_oe[i] = addr_use || port_direction[i];
      assign next_pin[i] = addr_use ? i_addr_hi.bits[7-i]
                         : (i_pattern.enable[i] ? i_pattern.data[i]
                                                : port_output_data[i]);
   end

   // pin 7: a20, then compare b, then pattern or plain port
   always_comb
   begin
      if (mode34 || (mode_ext && i_addr_hi.enable[0]))
      begin
         next_oe[7] = 1'b1;
         next_pin[7] = i_addr_hi.bits[0];
      end
      else if (b_set1)
      begin
         next_oe[7] = 1'b1;
         next_pin[7] = i_timer2.cmp_b;
      end
      else
      begin
         next_oe[7] = port_direction[7];
         next_pin[7] = i_pattern.enable[7] ? i_pattern.data[7]
                                           : port_output_data[7];
      end
   end

   // pin 6: a21, then compare a, then pattern or plain port
   always_comb
   begin
      if (mode_ext && i_addr_hi.enable[1])
      begin
         next_oe[6] = 1'b1;
         next_pin[6] = i_addr_hi.bits[1];
      end
      else if (a_set1)
      begin
         next_oe[6] = 1'b1;
         next_pin[6] = i_timer2.cmp_a;
      end
      else
      begin
         next_oe[6] = port_direction[6];
         next_pin[6] = i_pattern.enable[6] ? i_pattern.data[6]
                                           : port_output_data[6];
      end
   end

   // capture inputs need the pin free of address duty
   always_comb
   begin
      next_capture_en[1] = !mode34 && !(mode_ext && i_addr_hi.enable[0])
                         && i_timer2.io_ctrl_b[`PAMX_CTRL_CAPTURE_BIT]
                         && !i_timer2.pwm_select;
      next_capture_en[0] = !(mode_ext && i_addr_hi.enable[1])
                         && i_timer2.io_ctrl_a[`PAMX_CTRL_CAPTURE_BIT];
   end

   // pin outputs registered; costs one cycle but gives clean pads
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_pin <= 8'h00;
         o_pin_oe <= 8'h00;
         o_capture_en <= 2'h0;
         o_pin_level <= 8'h00;
      end
      else
      begin
         o_pin <= next_pin;
         o_pin_oe <= next_oe;
         o_capture_en <= next_capture_en;
         o_pin_level <= pin_sync;
      end
   end

   // checks
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);

   a_dir_reads_ones: assert property (
      (take && i_avs_read && dir_hit)
      |-> o_avs_readdata == 32'h000000ff)
      else $error("direction read did not return all ones");

   a_read_mix: assert property (
      (take && i_avs_read && data_hit)
      |-> o_avs_readdata[7:0] == $past(port_view))
      else $error("port read mixes data and pins wrongly");

   a_data_write: assert property (
      (take && i_avs_write && data_hit && i_avs_byteenable[0]
       && !i_sw_standby && !hw_clear)
      |=> port_output_data == $past(i_avs_writedata[7:0]))
      else $error("data write not stored");

   a_addr_pin_fixed: assert property (
      (mode34 && !hw_clear)
      |-> port_direction[7] && o_avs_readdata[31:8] == 24'h0)
      else $error("direction bit 7 lost in address mode");

   a_hw_clear: assert property (
      (hw_clear && !mode34) |=> port_direction == 8'h00
                                && port_output_data == 8'h00)
      else $error("hardware standby did not clear registers");

   a_hw_load_addr: assert property (
      (hw_clear && mode34) |=> port_direction == 8'h80 ##1 o_pin_oe[7])
      else $error("address mode direction load wrong");

   a_sw_hold: assert property (
      (i_sw_standby && !hw_clear) |=> $stable(port_direction)
                                     && $stable(port_output_data))
      else $error("software standby changed a register");

   a_plain_drive: assert property (
      (port_direction[0] && !i_pattern.enable[0])
      |=> o_pin_oe[0] && o_pin[0] == $past(port_output_data[0]))
      else $error("plain output pin 0 not driving data");

   a_pin7_timer: assert property (
      (!mode_ext && b_set1)
      |=> o_pin_oe[7] && o_pin[7] == $past(i_timer2.cmp_b))
      else $error("pin 7 not driving compare b");

   a_pin6_pattern: assert property (
      (!mode_ext && !a_set1 && port_direction[6] && i_pattern.enable[6])
      |=> o_pin_oe[6] && o_pin[6] == $past(i_pattern.data[6]))
      else $error("pin 6 not driving pattern bit");

   a_addr_out: assert property (
      (mode_ext && i_addr_hi.enable[3])
      |=> o_pin_oe[4] && o_pin[4] == $past(i_addr_hi.bits[3]))
      else $error("pin 4 not driving address bit 23");

   a_wait_answer: assert property (
      (req && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("waitrequest not one cycle low");

   c_dir_write: cover property (take && i_avs_write && dir_hit);
   c_data_read: cover property (take && i_avs_read && data_hit);
   c_pin7_timer: cover property (!mode_ext && b_set1 && o_pin_oe[7]);
   c_addr_mode: cover property (mode34 && o_pin_oe[7]);

endmodule
`default_nettype wire

// ===== verilog/pamx_defines.svh
// constants for the port a pin multiplexer: offsets, fields, resets, timing
`ifndef PAMX_DEFINES_SVH
`define PAMX_DEFINES_SVH

// register indices; byte address is four times the index
`define PAMX_DIR_INDEX 20'hee009
`define PAMX_DATA_INDEX 20'hfffd9

// reset values
`define PAMX_DIR_RESET_PLAIN 8'h00
`define PAMX_DIR_RESET_ADDR 8'h80
`define PAMX_DATA_RESET 8'h00
`define PAMX_DIR_READBACK 8'hff

// field positions
`define PAMX_ADDR20_PIN 7
`define PAMX_CTRL_CAPTURE_BIT 2

// operating modes
`define PAMX_MODE_3 3'h3
`define PAMX_MODE_4 3'h4
`define PAMX_MODE_5 3'h5

// cycles after reset release before the mode strap is trusted
`define PAMX_INIT_CYCLES 2'h3

`endif

// ===== verilog/pamx_pkg.sv
// types shared by the port a pin multiplexer
`default_nettype none
package pamx_pkg;

   // timer channel 2 controls and compare outputs
   typedef struct packed {
      logic cmp_b;
      logic cmp_a;
      logic [2:0] io_ctrl_b;
      logic [2:0] io_ctrl_a;
      logic pwm_select;
   } pamx_timer2_t;

   // pattern controller enables and data
   typedef struct packed {
      logic [7:0] enable;
      logic [7:0] data;
   } pamx_pattern_t;

   // bus release control enables (bit0 = a20) and address bits 23..20
   typedef struct packed {
      logic [3:0] enable;
      logic [3:0] bits;
   } pamx_addr_t;

endpackage
`default_nettype wire

// ===== test/pamx_partner.sv
// board-side model of the eight port a pins
`timescale 1ns/10ps
`default_nettype none

module pamx_partner
(
   input wire logic [7:0] i_board,
   input wire logic [7:0] i_drive,
   input wire logic [7:0] i_drive_oe,
   output logic [7:0] o_level
);

   // a driven pin shows the device value, a released one the board value
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         o_level[i] = i_drive_oe[i] ? i_drive[i] : i_board[i];
      end
   end

endmodule
`default_nettype wire

// ===== test/test_port_a_gpio_mux.sv
// self-checking bench for the port a pin multiplexer
`timescale 1ns/10ps
`default_nettype none

module test_port_a_gpio_mux;
   localparam logic [21:0] DIR_A = 22'h3b8024;
   localparam logic [21:0] DAT_A = 22'h3fff64;
   logic clk, rstn, rd, wr, wreq, hsn, ssb;
   logic [21:0] addr;
   logic [31:0] wdata, rdata;
   logic [3:0] be;
   logic [2:0] mode;
   logic [1:0] cap;
   logic [7:0] pin_in, pin_o, pin_oe, lvl, board, d;
   logic [31:0] s;
   pamx_pkg::pamx_timer2_t tmr;
   pamx_pkg::pamx_pattern_t pat;
   pamx_pkg::pamx_addr_t ahi;
   logic [7:0] expq[$];
   int n_fail, tests_run;

   pamx_port u_pamx_port (.i_clock(clk), .i_resetn(rstn),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdata), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_mode(mode),
      .i_hw_standby_n(hsn), .i_sw_standby(ssb), .i_timer2(tmr),
      .i_pattern(pat), .i_addr_hi(ahi), .i_pin(pin_in), .o_pin(pin_o),
      .o_pin_oe(pin_oe), .o_pin_level(lvl), .o_capture_en(cap));

   pamx_partner u_pamx_partner (.i_board(board), .i_drive(pin_o),
      .i_drive_oe(pin_oe), .o_level(pin_in));

   // galois step; fixed seed keeps runs repeatable
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
   endfunction

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // let n edges pass, then look between edges where outputs are settled
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // one avalon access; wreq read at an edge is the value sampled there,
   // so the request is released on the very edge that takes it
   task automatic bus(input logic w, input logic [21:0] a,
                      input logic [7:0] v);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= {24'h0, v};
      be <= 4'h1;
      do
      begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic rdx(input logic [21:0] a, input logic [7:0] e);
      expq.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask

   task automatic do_reset(input logic [2:0] m);
      @(posedge clk);
      mode <= m;
      rstn <= 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      settle(10);
   endtask

   // scoreboard: the oldest noted read value against data on the taking edge
   always @(negedge clk)
   begin
      if (rd === 1'b1 && wreq === 1'b0)
      begin
         if (expq.size() == 0)
            chk("unexpected_read", 8'h00, 8'hxx);
         else
            chk("readdata", expq.pop_front(), rdata[7:0]);
      end
   end

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = !clk;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // watchdog sized well above the planned sequence
   initial
   begin
      #(25 * 20000);
      n_fail++;
      conclude();
   end

   initial
   begin
      {rstn, rd, wr, ssb, addr, wdata, be, tmr, pat, ahi} = '0;
      hsn = 1'b1;
      mode = 3'h1;
      s = 32'h7179;
      board = 8'ha5;
      do_reset(3'h1);
      // reset state, read-back selection, unmapped place
      rdx(DAT_A, 8'ha5);
      rdx(DIR_A, 8'hff);
      rdx(22'h000010, 8'h00);
      chk("oe_reset", 8'h00, pin_oe);
      $display("test reset done");
      // plain output on low nibble, random data and board
      s = lfsr(s);
      d = s[7:0];
      board <= s[15:8];
      bus(1'b1, DIR_A, 8'h0f);
      bus(1'b1, DAT_A, d);
      settle(6);
      chk("oe_plain", 8'h0f, pin_oe);
      chk("out_plain", d & 8'h0f, pin_o & 8'h0f);
      chk("level", (d & 8'h0f) | (board & 8'hf0), lvl);
      rdx(DAT_A, (d & 8'h0f) | (board & 8'hf0));
      rdx(DIR_A, 8'hff);
      $display("test plain io done");
      // software standby keeps registers and drive
      ssb <= 1'b1;
      bus(1'b1, DAT_A, ~d);
      bus(1'b1, DIR_A, 8'h00);
      settle(4);
      chk("oe_swsb", 8'h0f, pin_oe);
      chk("out_swsb", d & 8'h0f, pin_o & 8'h0f);
      rdx(DAT_A, (d & 8'h0f) | (board & 8'hf0));
      ssb <= 1'b0;
      bus(1'b1, DIR_A, 8'h00);
      $display("test software standby done");
      // every timer control code and pwm on pins 7 and 6
      for (int k = 0; k < 16; k++)
      begin
         logic [3:0] kk;
         logic s7, s6;
         logic [7:0] ex;
         kk = k[3:0];
         s = lfsr(s);
         @(posedge clk);
         tmr <= '{s[0], s[1], kk[2:0], kk[2:0], kk[3]};
         settle(4);
         s7 = (kk[2:0] == 3'b001) || (kk[2:1] == 2'b01);
         s6 = kk[3] || s7;
         ex = {s7 & s[0], s6 & s[1], 6'h0};
         chk("tmr_oe", {s7, s6, 6'h0}, pin_oe & 8'hc0);
         chk("tmr_out", ex, pin_o & pin_oe & 8'hc0);
         chk("cap", {6'h0, kk[2] & !kk[3], kk[2]}, {6'h0, cap});
      end
      $display("test timer pins done");
      // pattern output needs the direction bit too
      @(posedge clk);
      tmr <= '0;
      pat <= '{8'hc0, 8'h40};
      bus(1'b1, DIR_A, 8'hc0);
      settle(4);
      chk("pat_oe", 8'hc0, pin_oe);
      chk("pat_out", 8'h40, pin_o & 8'hc0);
      @(posedge clk);
      pat <= '0;
      $display("test pattern done");
      // hardware standby clears data and direction
      bus(1'b1, DAT_A, 8'hff);
      @(posedge clk);
      hsn <= 1'b0;
      settle(5);
      @(posedge clk);
      hsn <= 1'b1;
      settle(8);
      chk("oe_hwsb", 8'h00, pin_oe);
      rdx(DAT_A, board);
      $display("test hardware standby done");
      // mode 3: pin 7 is address bit 20 and stays so
      ahi <= '{4'h0, 4'h1};
      do_reset(3'h3);
      chk("a20_oe", 8'h80, pin_oe);
      chk("a20_out", 8'h80, pin_o & 8'h80);
      rdx(DAT_A, {1'b0, board[6:0]});
      bus(1'b1, DIR_A, 8'h00);
      settle(4);
      chk("a20_keep", 8'h80, pin_oe);
      $display("test mode 3 done");
      // mode 5: address bit 20 only when enabled
      do_reset(3'h5);
      chk("m5_oe", 8'h00, pin_oe);
      @(posedge clk);
      ahi <= '{4'h1, 4'h1};
      settle(4);
      chk("m5_a20", 8'h80, pin_oe & pin_o);
      // all four address lines, read back as pin levels
      @(posedge clk);
      ahi <= '{4'hf, 4'ha};
      settle(4);
      chk("m5_oe_hi", 8'hf0, pin_oe);
      chk("m5_out_hi", 8'h50, pin_o & 8'hf0);
      rdx(DAT_A, 8'h50 | (board & 8'h0f));
      $display("test mode 5 done");
      conclude();
   end
endmodule
`default_nettype wire
